// ===== hw/awc_pkg.sv
// Package for the converter window comparator: SFR map, fields, resets.
// Assumes an 8-bit special-function-register bus with 8-bit addresses.
package awc_pkg;

    localparam int unsigned AWC_DW = 8;
    localparam int unsigned AWC_AW = 8;

    // SFR addresses
    localparam logic [7:0] AWC_ADDR_UL_LO = 8'hC4;
    localparam logic [7:0] AWC_ADDR_UL_HI = 8'hC5;
    localparam logic [7:0] AWC_ADDR_LL_LO = 8'hC6;
    localparam logic [7:0] AWC_ADDR_LL_HI = 8'hC7;
    localparam logic [7:0] AWC_ADDR_CTRL  = 8'hE8;
    localparam logic [7:0] AWC_ADDR_RES_LO = 8'hBE;
    localparam logic [7:0] AWC_ADDR_RES_HI = 8'hBF;

    // Reset values
    localparam logic [7:0] AWC_RST_UL = 8'hFF;
    localparam logic [7:0] AWC_RST_LL = 8'h00;
    localparam logic [7:0] AWC_RST_CTRL = 8'h00;

    // Control register bit positions
    localparam int unsigned AWC_BIT_DONE = 5;
    localparam int unsigned AWC_BIT_BUSY = 4;
    localparam int unsigned AWC_BIT_WIN  = 1;
    localparam int unsigned AWC_BIT_LJST = 0;

    // Converter figures
    localparam int unsigned AWC_RES_BITS  = 10;
    localparam int unsigned AWC_CONV_CLKS = 16;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } awc_sfr_req_t;

    typedef struct packed {
        logic                    busy;
        logic                    diff;
        logic [AWC_RES_BITS-1:0] code;
    } awc_conv_t;

endpackage : awc_pkg

// ===== hw/awc_window_check.sv
// Combinational window test of one 16-bit data word against two limits.
// Assumes the word and limits already share justification and sign form.
module awc_window_check (
    // Operands
    input  wire logic [15:0] i_data,
    input  wire logic [15:0] i_upper,
    input  wire logic [15:0] i_lower,
    input  wire logic        i_signed,
    // Result
    output logic             o_match
);
    logic gt_up;
    logic lt_lo;
    logic inside_mode;

    always_comb begin
        if (i_signed) begin
            gt_up       = $signed(i_data) > $signed(i_upper);
            lt_lo       = $signed(i_data) < $signed(i_lower);
            inside_mode = $signed(i_lower) > $signed(i_upper);
        end else begin
            gt_up       = i_data > i_upper;
            lt_lo       = i_data < i_lower;
            inside_mode = i_lower > i_upper;
        end
        // Ordering of the limits picks inside or outside window
        o_match = inside_mode ? (gt_up && lt_lo) : (gt_up || lt_lo);
    end

endmodule : awc_window_check

// ===== hw/awc_window_comparator.sv
// Window comparator for the primary converter, with its SFR registers.
// Assumes converter busy falls once per finished 16-clock conversion
// and the code input is stable on that edge.
// Notes on behaviour
// - Every finished conversion is compared with no software action.
// - A window hit sets the match flag in the control register.
// - Each limit word is split into high and low byte registers.
// - Limit ordering alone selects inside-window or outside-window flagging.
// - Upper limit high byte at 0xC5, read/write, resets to FF.
// - Upper limit low byte at 0xC4, read/write, resets to FF.
// - Lower limit high byte at 0xC7, read/write, resets to 00.
// - One compare per 16-clock conversion, using the fresh word.
// - Done flag sets on busy falling; compare uses that conversion's word.
// - Justification bit: 0 right-justifies, 1 left-justifies the word.
module awc_window_comparator
    import awc_pkg::*;
(
    // Clock and reset
    input  wire logic                  i_clk_sys,
    input  wire logic                  i_rst_n,
    // SFR bus
    input  wire awc_pkg::awc_sfr_req_t i_sfr,
    output logic [7:0]                 o_sfr_rdata,
    output logic                       o_sfr_hit,
    // Converter
    input  wire awc_pkg::awc_conv_t    i_conv,
    // Status
    output logic                       o_window_match_flag,
    output logic                       o_conversion_complete_flag
);
    import awc_pkg::*;

    typedef struct packed {
        logic [7:0]  ul_lo;
        logic [7:0]  ul_hi;
        logic [7:0]  ll_lo;
        logic [7:0]  ll_hi;
        logic        ljst;
        logic        done;
        logic        win;
        logic        busy_prev;
        logic        diff;
        logic [15:0] data;
    } awc_state_t;

    awc_state_t s_q;
    awc_state_t s_d;
    logic [15:0] word;
    logic        hit;
    logic        busy_fall;

    // Justify the fresh code as it would appear in the data registers
    always_comb begin
        if (i_conv.diff) begin
            word = {{6{i_conv.code[9]}}, i_conv.code};
        end else begin
            word = {6'h00, i_conv.code};
        end
        if (s_q.ljst) begin
            word = {i_conv.code, 6'h00};
        end
    end

    // Busy must be seen high once after reset before a fall can count
    assign busy_fall = s_q.busy_prev && !i_conv.busy;

    awc_window_check awc_window_check_inst (
        .i_data   (word),
        .i_upper  ({s_q.ul_hi, s_q.ul_lo}),
        .i_lower  ({s_q.ll_hi, s_q.ll_lo}),
        .i_signed (i_conv.diff),
        .o_match  (hit)
    );

    always_comb begin
        s_d = s_q;
        s_d.busy_prev = i_conv.busy;
        if (i_sfr.wr) begin
            unique case (i_sfr.addr)
                AWC_ADDR_UL_LO: s_d.ul_lo = i_sfr.wdata;
                AWC_ADDR_UL_HI: s_d.ul_hi = i_sfr.wdata;
                AWC_ADDR_LL_LO: s_d.ll_lo = i_sfr.wdata;
                AWC_ADDR_LL_HI: s_d.ll_hi = i_sfr.wdata;
                AWC_ADDR_CTRL: begin
                    s_d.ljst = i_sfr.wdata[AWC_BIT_LJST];
                    s_d.win  = i_sfr.wdata[AWC_BIT_WIN];
                    s_d.done = i_sfr.wdata[AWC_BIT_DONE];
                end
                default: ;
            endcase
        end
        // Hardware set wins over a software clear in the same cycle
        if (busy_fall) begin
            s_d.done = 1'b1;
            s_d.data = word;
            s_d.diff = i_conv.diff;
            if (hit) begin
                s_d.win = 1'b1;
            end
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            s_q <= '{ul_lo: AWC_RST_UL, ul_hi: AWC_RST_UL,
                     ll_lo: AWC_RST_LL, ll_hi: AWC_RST_LL,
                     ljst: 1'b0, done: 1'b0, win: 1'b0, busy_prev: 1'b0,
                     diff: 1'b0, data: 16'h0000};
        end else begin
            s_q <= s_d;
        end
    end

    // Read mux
    always_comb begin
        o_sfr_hit   = 1'b1;
        o_sfr_rdata = 8'h00;
        unique case (i_sfr.addr)
            AWC_ADDR_UL_LO: o_sfr_rdata = s_q.ul_lo;
            AWC_ADDR_UL_HI: o_sfr_rdata = s_q.ul_hi;
            AWC_ADDR_LL_LO: o_sfr_rdata = s_q.ll_lo;
            AWC_ADDR_LL_HI: o_sfr_rdata = s_q.ll_hi;
            AWC_ADDR_RES_LO: o_sfr_rdata = s_q.data[7:0];
            AWC_ADDR_RES_HI: o_sfr_rdata = s_q.data[15:8];
            AWC_ADDR_CTRL: begin
                o_sfr_rdata[AWC_BIT_DONE] = s_q.done;
                o_sfr_rdata[AWC_BIT_BUSY] = s_q.busy_prev;
                o_sfr_rdata[AWC_BIT_WIN]  = s_q.win;
                o_sfr_rdata[AWC_BIT_LJST] = s_q.ljst;
            end
            default: o_sfr_hit = 1'b0;
        endcase
    end

    assign o_window_match_flag        = s_q.win;
    assign o_conversion_complete_flag = s_q.done;

    // Match on a finished conversion sets the flag next cycle
    flag_set_a: assert property (
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        busy_fall && hit |=> o_window_match_flag)
        else $error("window hit did not set match flag");

    // Flag never drops without a control write
    flag_hold_a: assert property (
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        o_window_match_flag && !(i_sfr.wr && i_sfr.addr == AWC_ADDR_CTRL)
        |=> o_window_match_flag)
        else $error("match flag cleared by hardware");

    // Flag rises only after a compare hit or a software set
    flag_cause_a: assert property (
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        $rose(o_window_match_flag) |-> $past(busy_fall && hit)
            || $past(i_sfr.wr && i_sfr.addr == AWC_ADDR_CTRL))
        else $error("match flag rose without cause");

    // Done follows busy falling, with that conversion's word
    done_set_a: assert property (
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        busy_fall |=> o_conversion_complete_flag && s_q.data == $past(word))
        else $error("done flag or data not captured");

    // Done stays until software writes the control register
    done_hold_a: assert property (
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        o_conversion_complete_flag && !(i_sfr.wr && i_sfr.addr == AWC_ADDR_CTRL)
        |=> o_conversion_complete_flag)
        else $error("done flag cleared by hardware");

    // Limit writes land in their own byte
    upper_hi_a: assert property (
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        i_sfr.wr && i_sfr.addr == AWC_ADDR_UL_HI
        |=> s_q.ul_hi == $past(i_sfr.wdata))
        else $error("upper high byte write lost");

    upper_lo_a: assert property (
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        i_sfr.wr && i_sfr.addr == AWC_ADDR_UL_LO
        |=> s_q.ul_lo == $past(i_sfr.wdata))
        else $error("upper low byte write lost");

    lower_hi_a: assert property (
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        i_sfr.wr && i_sfr.addr == AWC_ADDR_LL_HI
        |=> s_q.ll_hi == $past(i_sfr.wdata))
        else $error("lower high byte write lost");

    lower_lo_a: assert property (
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        i_sfr.wr && i_sfr.addr == AWC_ADDR_LL_LO
        |=> s_q.ll_lo == $past(i_sfr.wdata))
        else $error("lower low byte write lost");

    // Left justify puts code in top ten bits
    left_just_a: assert property (
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        s_q.ljst |-> word[5:0] == 6'h00 && word[15:6] == i_conv.code)
        else $error("left justification wrong");

    // Right justify extends the sign only for differential codes
    right_just_a: assert property (
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        !s_q.ljst |-> word[9:0] == i_conv.code
            && word[15:10] == (i_conv.diff ? {6{i_conv.code[9]}} : 6'h00))
        else $error("right justification wrong");

    // No compare without a busy fall
    one_compare_a: assert property (
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        !busy_fall && !(i_sfr.wr && i_sfr.addr == AWC_ADDR_CTRL)
        |=> $stable(o_window_match_flag) && $stable(s_q.data))
        else $error("compare outside a conversion end");

    // Control write loads justify and both flags when no fall competes
    ctrl_load_a: assert property (
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        i_sfr.wr && i_sfr.addr == AWC_ADDR_CTRL && !busy_fall
        |=> s_q.ljst == $past(i_sfr.wdata[AWC_BIT_LJST])
            && o_window_match_flag == $past(i_sfr.wdata[AWC_BIT_WIN])
            && o_conversion_complete_flag == $past(i_sfr.wdata[AWC_BIT_DONE]))
        else $error("control write not loaded");

    // A clear meeting a hit in one cycle must lose
    set_wins_a: assert property (
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        busy_fall && hit && i_sfr.wr && i_sfr.addr == AWC_ADDR_CTRL
        |=> o_window_match_flag && o_conversion_complete_flag)
        else $error("software clear beat a hardware set");

    // A miss leaves a clear flag clear
    miss_quiet_a: assert property (
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        busy_fall && !hit && !o_window_match_flag
            && !(i_sfr.wr && i_sfr.addr == AWC_ADDR_CTRL)
        |=> !o_window_match_flag)
        else $error("match flag set on a miss");

    // Foreign addresses read as zero
    unmapped_read_a: assert property (
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        !o_sfr_hit |-> o_sfr_rdata == 8'h00)
        else $error("unmapped read returned data");

endmodule : awc_window_comparator

// ===== testbench/test_adc_window_comparator.sv
// Self-checking bench for the converter window comparator.
// Assumes awc_pkg and the design files are compiled first.
module test_adc_window_comparator;
    timeunit 1ns;
    timeprecision 1ns;
    import awc_pkg::*;

    logic         clk_sys = 1'b0;
    logic         rst_n   = 1'b0;
    awc_sfr_req_t sfr     = '0;
    awc_conv_t    conv    = '0;
    logic [7:0]   sfr_rdata;
    logic         sfr_hit;
    logic         win_flag;
    logic         done_flag;
    logic [8:0]   notes[$];
    logic [8:0]   exp_q;
    logic [15:0]  up;
    logic [15:0]  lo;
    logic [15:0]  dw;
    logic [31:0]  r;
    logic [9:0]   code;
    logic         ljst;
    logic         diff;
    logic         win_exp;
    int           mismatches = 0;
    int           tests_run  = 0;
    int           cycles     = 0;
    int           seed       = 32'h394A694E;

    awc_window_comparator awc_window_comparator_inst (
        .i_clk_sys                  (clk_sys),
        .i_rst_n                    (rst_n),
        .i_sfr                      (sfr),
        .o_sfr_rdata                (sfr_rdata),
        .o_sfr_hit                  (sfr_hit),
        .i_conv                     (conv),
        .o_window_match_flag        (win_flag),
        .o_conversion_complete_flag (done_flag)
    );

    always #5 clk_sys = ~clk_sys;

    task automatic end_of_test();
        if (mismatches == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : end_of_test

    // A hang counts as a failure
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles > 10000) begin
            mismatches++;
            end_of_test();
        end
    end

    // Reads are combinational, so the note is compared at the edge inside the read
    always @(posedge clk_sys) begin
        if (sfr.rd) begin
            exp_q = notes.pop_front();
            tests_run++;
            if ({sfr_hit, sfr_rdata} !== exp_q) begin
                mismatches++;
                $display("wrong value at %0t: addr %h read %h", $time, sfr.addr,
                         {sfr_hit, sfr_rdata});
            end
            if (sfr.addr == 8'hE8 && {done_flag, win_flag} !== {exp_q[5], exp_q[1]}) begin
                mismatches++;
                $display("wrong value at %0t: status ports disagree", $time);
            end
        end
    end

    function automatic logic [15:0] shape(logic [9:0] c, logic d, logic j);
        if (j)
            return {c, 6'h00};
        return d ? {{6{c[9]}}, c} : {6'h00, c};
    endfunction : shape

    function automatic logic hit(logic [15:0] x, logic [15:0] u, logic [15:0] l, logic d);
        logic gt;
        logic lt;
        logic between;
        gt      = d ? ($signed(x) > $signed(u)) : (x > u);
        lt      = d ? ($signed(x) < $signed(l)) : (x < l);
        between = d ? ($signed(l) > $signed(u)) : (l > u);
        return between ? (gt && lt) : (gt || lt);
    endfunction : hit

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        sfr.wr    = 1'b1;
        sfr.addr  = a;
        sfr.wdata = d;
        @(negedge clk_sys);
        sfr.wr = 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic h, input logic [7:0] d);
        @(negedge clk_sys);
        sfr.rd   = 1'b1;
        sfr.addr = a;
        notes.push_back({h, d});
        @(negedge clk_sys);
        sfr.rd = 1'b0;
    endtask : rd

    // Code is scrambled right after the fall to prove the word was captured then
    task automatic convert();
        @(negedge clk_sys);
        conv.busy = 1'b1;
        conv.diff = diff;
        repeat (15) @(negedge clk_sys);
        conv.busy = 1'b0;
        conv.code = code;
        @(negedge clk_sys);
        conv.code = ~code;
        @(negedge clk_sys);
    endtask : convert

    initial begin
        repeat (3) @(negedge clk_sys);
        rst_n = 1'b1;
        rd(8'hC5, 1'b1, 8'hFF);
        rd(8'hC4, 1'b1, 8'hFF);
        rd(8'hC7, 1'b1, 8'h00);
        rd(8'hE8, 1'b1, 8'h00);
        wr(8'hC3, 8'h5A);
        rd(8'hC3, 1'b0, 8'h00);
        win_exp = 1'b0;
        for (int i = 0; i < 60; i++) begin
            r    = $random(seed);
            diff = r[0];
            ljst = r[1];
            code = r[11:2];
            up   = shape(r[21:12], diff, ljst);
            r    = $random(seed);
            lo   = shape(r[9:0], diff, ljst);
            wr(8'hC5, up[15:8]);
            wr(8'hC4, up[7:0]);
            wr(8'hC7, lo[15:8]);
            wr(8'hC6, lo[7:0]);
            rd(8'hC5, 1'b1, up[15:8]);
            rd(8'hC7, 1'b1, lo[15:8]);
            if (i % 3 == 0)
                win_exp = 1'b0;
            wr(8'hE8, {6'h00, win_exp, ljst});
            convert();
            dw      = shape(code, diff, ljst);
            win_exp = win_exp | hit(dw, up, lo, diff);
            rd(8'hE8, 1'b1, {2'h0, 1'b1, 3'h0, win_exp, ljst});
            rd(8'hBF, 1'b1, dw[15:8]);
            rd(8'hBE, 1'b1, dw[7:0]);
        end
        // No busy fall means no compare, whatever the code does
        wr(8'hE8, 8'h00);
        repeat (20) begin
            @(negedge clk_sys);
            r         = $random(seed);
            conv.code = r[9:0];
        end
        rd(8'hE8, 1'b1, 8'h00);
        // A clear in the cycle of a hit loses to the hit
        wr(8'hC5, 8'h00);
        wr(8'hC4, 8'h00);
        wr(8'hC7, 8'h00);
        wr(8'hC6, 8'h00);
        conv.busy = 1'b1;
        conv.diff = 1'b0;
        repeat (16) @(negedge clk_sys);
        conv.busy = 1'b0;
        conv.code = 10'h155;
        sfr.wr    = 1'b1;
        sfr.addr  = 8'hE8;
        sfr.wdata = 8'h00;
        @(negedge clk_sys);
        sfr.wr = 1'b0;
        rd(8'hE8, 1'b1, 8'h22);
        rd(8'hBF, 1'b1, 8'h01);
        rd(8'hBE, 1'b1, 8'h55);
        end_of_test();
    end
endmodule : test_adc_window_comparator
